// File: pvic_pkg.sv
// pvic_pkg: constants and types shared by the interrupt controller files
// assumes a single 25 MHz clock domain and no register bus
package pvic_pkg;
   localparam int PVIC_NSRC = 15;
   localparam int PVIC_IDW = 4;
   localparam int PVIC_NLVL = 4;
   // peripheral cycle length in peripheral clock periods
   localparam int PVIC_PER_CYCLE = 6;
   // vector = base + slot * stride
   localparam logic [15:0] PVIC_VEC_BASE = 16'h0003;
   localparam int PVIC_VEC_SHIFT = 3;
   // polling slot numbers
   localparam logic [3:0] PVIC_SLOT_PIN_A = 4'h0;
   localparam logic [3:0] PVIC_SLOT_TMR0 = 4'h1;
   localparam logic [3:0] PVIC_SLOT_PIN_B = 4'h2;
   localparam logic [3:0] PVIC_SLOT_TMR1 = 4'h3;
   localparam logic [3:0] PVIC_SLOT_KEYPAD = 4'hb;
   localparam logic [7:0] PVIC_REG_RST = 8'h00;
   localparam logic [PVIC_NLVL-1:0] PVIC_INPROG_RST = 4'h0;
   typedef enum logic [2:0]
   {
      PVIC_IDLE = 3'b001,
      PVIC_OFFER = 3'b010,
      PVIC_ACK = 3'b100
   } pvic_state_t;
endpackage

// File: pvic_pin_if.sv
// pvic_pin_if: sampled external pin events between sampler and core
// assumes both ends run on ref_clk_in
`timescale 1ns/10ps
interface pvic_pin_if;
   logic [1:0] low_level;
   logic [1:0] fall_pulse;
   logic keypad_level;
   modport sampler (output low_level, output fall_pulse, output keypad_level);
   modport core (input low_level, input fall_pulse, input keypad_level);
endinterface

// File: pvic_pin_sampler.sv
// pvic_pin_sampler: synchronises and samples the irq pins per peripheral cycle
// assumes pins are asynchronous; per_clk_en_in is a one-cycle enable pulse
`timescale 1ns/10ps
module pvic_pin_sampler
   import pvic_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic per_clk_en_in,
   input wire logic [1:0] ext_irq_pin_in,
   input wire logic keypad_irq_input_in,
   pvic_pin_if.sampler pins
);
   logic [2:0] sync1, sync2, samp, prev;
   logic [2:0] next_samp, next_prev;
   logic [2:0] div, next_div;
   logic per_cycle;
   logic per_cycle_d;

   // peripheral cycle divider: six peripheral clocks
   always_comb
   begin
      next_div = div;
      per_cycle = 1'b0;
      if (per_clk_en_in)
      begin
         if (div == 3'(PVIC_PER_CYCLE - 1))
         begin
            next_div = 3'h0;
            per_cycle = 1'b1;
         end
         else
            next_div = div + 3'h1;
      end
   end

   // sample once per peripheral cycle, remember previous sample
   always_comb
   begin
      next_samp = samp;
      next_prev = prev;
      if (per_cycle)
      begin
         next_samp = sync2;
         next_prev = samp;
      end
   end

   // pins idle high; reset to idle avoids a false edge
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         sync1 <= 3'h7;
         sync2 <= 3'h7;
         samp <= 3'h7;
         prev <= 3'h7;
         div <= 3'h0;
      end
      else
      begin
         sync1 <= {keypad_irq_input_in, ext_irq_pin_in};
         sync2 <= sync1;
         samp <= next_samp;
         prev <= next_prev;
         div <= next_div;
      end
   end

   assign pins.low_level = ~samp[1:0];
   // falling edge seen between two samples, one clock wide
   assign pins.fall_pulse = prev[1:0] & ~samp[1:0] & {2{per_cycle_d}};
   assign pins.keypad_level = ~samp[2];

   // delayed strobe lines the edge pulse up with the fresh sample
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
         per_cycle_d <= 1'b0;
      else
         per_cycle_d <= per_cycle;
   end
endmodule // pvic_pin_sampler

// File: pvic_arbiter.sv
// pvic_arbiter: picks the winning source by level then polling order
// assumes combinational use inside the controller core
`timescale 1ns/10ps
module pvic_arbiter
   import pvic_pkg::*;
#(
   parameter int NSRC = PVIC_NSRC
)
(
   input wire logic [NSRC-1:0] req_in,
   input wire logic [NSRC-1:0] prio_high_bit_in,
   input wire logic [NSRC-1:0] prio_low_bit_in,
   output logic found_out,
   output logic [3:0] slot_out,
   output logic [1:0] level_out
);
   logic [1:0] lvl;

   // highest level first, then lowest slot number within it
   always_comb
   begin
      found_out = 1'b0;
      slot_out = 4'h0;
      level_out = 2'h0;
      lvl = 2'h0;
      for (int l = PVIC_NLVL - 1; l >= 0; l--)
      begin
         for (int s = 0; s < NSRC; s++)
         begin
            lvl = {prio_high_bit_in[s], prio_low_bit_in[s]};
            if (!found_out && req_in[s] && lvl == 2'(l))
            begin
               found_out = 1'b1;
               slot_out = 4'(s);
               level_out = lvl;
            end
         end
      end
   end
endmodule // pvic_arbiter

// File: pvic_ctrl.sv
// pvic_ctrl: prioritised vectored interrupt controller top
// assumes the execution unit acks a vector once the current instruction ends
// Functional notes
// - each source has a two-bit level, 0 lowest, 3 highest.
// - preempt only when request level strictly exceeds level in progress.
// - equal levels resolve by fixed polling order, slot 0 first.
// - vector equals 0003h plus eight times the slot number.
// - requests are latched into pending flags until taken or cleared; only pin and timer requests latch here, keypad and peripheral lines do not.
// - execution unit finishes instruction, saves PC, loads vector on ack.
// - return from interrupt clears the top in-progress marker.
// - per-source enables and per-source priority bits in 8-bit registers.
// - trigger type 0 means low level, 1 means falling edge.
// - pin events set flags; edge flags clear on vectoring.
// - hardware clears only edge pin and timer flags on vectoring.
// - low level on either pin raises a power-down wake request.
// - pins and keypad sampled once per six peripheral clocks.
// - global enable clear blocks all sources.
`timescale 1ns/10ps
module pvic_ctrl
   import pvic_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic per_clk_en_in,
   input wire logic ext_irq_pin_a_in,
   input wire logic ext_irq_pin_b_in,
   input wire logic keypad_irq_input_in,
   input wire logic [1:0] ext_trigger_type_in,
   input wire logic [1:0] ext_flag_clear_in,
   input wire logic tmr0_overflow_in,
   input wire logic tmr1_overflow_in,
   input wire logic [14:0] periph_req_in,
   input wire logic [7:0] irq_enable_reg_a_in,
   input wire logic [7:0] irq_enable_reg_b_in,
   input wire logic [7:0] prio_high_reg_a_in,
   input wire logic [7:0] prio_high_reg_b_in,
   input wire logic [7:0] prio_low_reg_a_in,
   input wire logic [7:0] prio_low_reg_b_in,
   input wire logic vector_ack_in,
   input wire logic return_from_interrupt_in,
   output logic irq_req_out,
   output logic [15:0] irq_vector_out,
   output logic [3:0] irq_slot_out,
   output logic [1:0] ext_request_flag_out,
   output logic [1:0] tmr_overflow_flag_out,
   output logic [3:0] in_progress_out,
   output logic wake_out
);
   pvic_pin_if pins ();
   logic [1:0] ext_flag, next_ext_flag;
   logic [1:0] tmr_flag, next_tmr_flag;
   logic [PVIC_NLVL-1:0] inprog, next_inprog;
   pvic_state_t state, next_state;
   logic [14:0] pending, enable, prio_h, prio_l, eligible;
   logic found;
   logic [3:0] win_slot;
   logic [1:0] win_lvl;
   logic [2:0] cur_lvl;
   logic offer;
   logic [15:0] next_vector;
   logic [3:0] next_slot;
   logic [1:0] win_lvl_held, next_lvl_held;

   function automatic logic [15:0] pvic_vec(input logic [3:0] slot);
      pvic_vec = PVIC_VEC_BASE + ({12'h000, slot} << PVIC_VEC_SHIFT);
   endfunction

   // current level: one above the highest marker, zero when none
   function automatic logic [2:0] pvic_top(input logic [3:0] m);
      pvic_top = 3'h0;
      for (int i = 0; i < PVIC_NLVL; i++)
         if (m[i])
            pvic_top = 3'(i + 1);
   endfunction

   pvic_pin_sampler u_sampler (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .per_clk_en_in(per_clk_en_in),
      .ext_irq_pin_in({ext_irq_pin_b_in, ext_irq_pin_a_in}),
      .keypad_irq_input_in(keypad_irq_input_in),
      .pins(pins.sampler)
   );

   // enable and priority bits laid out by polling slot
   assign enable = {1'b0, irq_enable_reg_b_in[6], 1'b0,
      irq_enable_reg_b_in[4:0], irq_enable_reg_a_in[6:0]};
   assign prio_h = {1'b0, prio_high_reg_b_in[6:0], prio_high_reg_a_in[6:0]};
   assign prio_l = {1'b0, prio_low_reg_b_in[6:0], prio_low_reg_a_in[6:0]};

   // pending flags: pins and timers held here, peripherals hold their own
   always_comb
   begin
      pending = periph_req_in;
      pending[PVIC_SLOT_PIN_A] = ext_flag[0];
      pending[PVIC_SLOT_PIN_B] = ext_flag[1];
      pending[PVIC_SLOT_TMR0] = tmr_flag[0];
      pending[PVIC_SLOT_TMR1] = tmr_flag[1];
      pending[PVIC_SLOT_KEYPAD] = periph_req_in[PVIC_SLOT_KEYPAD]
         | pins.keypad_level;
      pending[12] = 1'b0;
      pending[14] = 1'b0;
      // global gate checked before per-source enables
      eligible = pending & enable & {15{irq_enable_reg_a_in[7]}};
   end

   pvic_arbiter #(.NSRC(PVIC_NSRC)) u_arb (
      .req_in(eligible),
      .prio_high_bit_in(prio_h),
      .prio_low_bit_in(prio_l),
      .found_out(found),
      .slot_out(win_slot),
      .level_out(win_lvl)
   );

   assign cur_lvl = pvic_top(inprog);
   // strictly higher level only; equal waits
   assign offer = found && ({1'b0, win_lvl} >= cur_lvl) &&
      !(inprog[win_lvl]);

   // flags: a set in the same cycle as a clear wins
   always_comb
   begin
      next_ext_flag = ext_flag;
      next_tmr_flag = tmr_flag;
      for (int n = 0; n < 2; n++)
      begin
         if (ext_flag_clear_in[n])
            next_ext_flag[n] = 1'b0;
         if (state == PVIC_OFFER && vector_ack_in && ext_trigger_type_in[n]
             && irq_slot_out == (n == 0 ? PVIC_SLOT_PIN_A : PVIC_SLOT_PIN_B))
            next_ext_flag[n] = 1'b0;
         if (ext_trigger_type_in[n] ? pins.fall_pulse[n]
             : pins.low_level[n])
            next_ext_flag[n] = 1'b1;
      end
      if (state == PVIC_OFFER && vector_ack_in)
      begin
         if (irq_slot_out == PVIC_SLOT_TMR0)
            next_tmr_flag[0] = 1'b0;
         if (irq_slot_out == PVIC_SLOT_TMR1)
            next_tmr_flag[1] = 1'b0;
      end
      if (tmr0_overflow_in)
         next_tmr_flag[0] = 1'b1;
      if (tmr1_overflow_in)
         next_tmr_flag[1] = 1'b1;
   end

   // offer handshake and in-progress markers
   always_comb
   begin
      next_state = state;
      next_inprog = inprog;
      next_vector = irq_vector_out;
      next_slot = irq_slot_out;
      next_lvl_held = win_lvl_held;
      if (return_from_interrupt_in)
         next_inprog = inprog & ~(4'h1 << (cur_lvl - 3'h1));
      case (state)
         PVIC_IDLE:
         begin
            next_lvl_held = win_lvl; // frozen once the offer is up
            if (offer && !return_from_interrupt_in)
            begin
               next_state = PVIC_OFFER;
               next_vector = pvic_vec(win_slot);
               next_slot = win_slot;
            end
         end
         PVIC_OFFER:
         begin
            if (vector_ack_in)
            begin
               // the unit saves PC and jumps; level now in progress
               next_inprog = next_inprog | (4'h1 << win_lvl_held);
               next_state = PVIC_ACK;
            end
            else if (!offer || win_slot != irq_slot_out)
               next_state = PVIC_IDLE; // re-arbitrate when winner changes
         end
         PVIC_ACK:
            next_state = PVIC_IDLE; // one cycle for the flag clear to land
         default:
            next_state = PVIC_IDLE;
      endcase
   end

   // pin and timer request flags
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         ext_flag <= 2'h0;
         tmr_flag <= 2'h0;
      end
      else
      begin
         ext_flag <= next_ext_flag;
         tmr_flag <= next_tmr_flag;
      end
   end

   // offer state, held vector and level, in-progress markers
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         inprog <= PVIC_INPROG_RST;
         state <= PVIC_IDLE;
         irq_vector_out <= 16'h0000;
         irq_slot_out <= 4'h0;
         win_lvl_held <= 2'h0;
      end
      else
      begin
         inprog <= next_inprog;
         state <= next_state;
         irq_vector_out <= next_vector;
         irq_slot_out <= next_slot;
         win_lvl_held <= next_lvl_held;
      end
   end

   assign irq_req_out = (state == PVIC_OFFER);
   assign ext_request_flag_out = ext_flag;
   assign tmr_overflow_flag_out = tmr_flag;
   assign in_progress_out = inprog;
   // wake works without the global enable
   assign wake_out = |pins.low_level;
endmodule // pvic_ctrl

// File: pvic_checker.sv
// pvic_checker: port-level assertions for the interrupt controller
// assumes a bind to pvic_ctrl, one clock, reset active high
`timescale 1ns/10ps
module pvic_checker
   import pvic_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic [1:0] ext_trigger_type_in,
   input wire logic tmr0_overflow_in,
   input wire logic [7:0] irq_enable_reg_a_in,
   input wire logic [7:0] irq_enable_reg_b_in,
   input wire logic [7:0] prio_high_reg_a_in,
   input wire logic [7:0] prio_high_reg_b_in,
   input wire logic [7:0] prio_low_reg_a_in,
   input wire logic [7:0] prio_low_reg_b_in,
   input wire logic vector_ack_in,
   input wire logic return_from_interrupt_in,
   input wire logic irq_req_out,
   input wire logic [15:0] irq_vector_out,
   input wire logic [3:0] irq_slot_out,
   input wire logic [1:0] ext_request_flag_out,
   input wire logic [1:0] tmr_overflow_flag_out,
   input wire logic [3:0] in_progress_out
);
   logic [14:0] ph, pl, en, en_q;
   logic [1:0] lvl;
   logic acc;
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (rst_in);
   // slot-indexed views of the enable and priority bytes
   assign ph = {1'b0, prio_high_reg_b_in[6:0], prio_high_reg_a_in[6:0]};
   assign pl = {1'b0, prio_low_reg_b_in[6:0], prio_low_reg_a_in[6:0]};
   assign en = {1'b0, irq_enable_reg_b_in[6], 1'b0, irq_enable_reg_b_in[4:0],
      irq_enable_reg_a_in[6:0]} & {15{irq_enable_reg_a_in[7]}};
   assign lvl = {ph[irq_slot_out], pl[irq_slot_out]};
   assign acc = irq_req_out && vector_ack_in;
   // offer lags an enable change by one cycle, so keep the old mask too
   always_ff @(posedge ref_clk_in or posedge rst_in)
      if (rst_in)
         en_q <= '0;
      else
         en_q <= en;
   vec_map_a: assert property (irq_req_out |->
      irq_vector_out == {9'h000, irq_slot_out, 3'h0} + 16'h0003)
      else $error("vector does not match slot");
   src_enabled_a: assert property (irq_req_out |->
      (en[irq_slot_out] || en_q[irq_slot_out]))
      else $error("disabled source offered");
   global_off_a: assert property (!irq_enable_reg_a_in[7] [*2] |->
      !irq_req_out) else $error("offer with global enable clear");
   above_level_a: assert property (irq_req_out |->
      (in_progress_out >> lvl) == 4'h0) else $error("offer not above level");
   ack_drop_a: assert property (acc |=> !irq_req_out [*2])
      else $error("offer not withdrawn after ack");
   mark_set_a: assert property (acc |=> in_progress_out[$past(lvl)])
      else $error("level marker not set on ack");
   mark_clear_a: assert property (return_from_interrupt_in && !acc &&
      in_progress_out != 4'h0 |=> $countones(in_progress_out) ==
      $countones($past(in_progress_out)) - 1)
      else $error("return did not clear one marker");
   edge_clear_a: assert property (acc && irq_slot_out == 4'h0 &&
      ext_trigger_type_in[0] |=> !ext_request_flag_out[0])
      else $error("edge flag kept after vectoring");
   tmr_clear_a: assert property (acc && irq_slot_out == 4'h1 &&
      !tmr0_overflow_in |=> !tmr_overflow_flag_out[0])
      else $error("timer flag kept after vectoring");
   cover property (in_progress_out == 4'ha);
   cover property (acc && irq_slot_out == 4'h0);
   cover property (acc && irq_slot_out == 4'hd);
endmodule // pvic_checker

// File: pvic_exec_model.sv
// pvic_exec_model: execution unit stand-in that takes offered vectors
// assumes irq_req_in is the controller offer, sampled on the rising edge
`timescale 1ns/10ps
module pvic_exec_model
   import pvic_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic irq_req_in,
   input wire logic [1:0] delay_in,
   output logic vector_ack_out
);
   logic [1:0] cnt;
   // stall delay_in cycles as if an instruction were still finishing
   always_ff @(posedge ref_clk_in or posedge rst_in)
      if (rst_in)
      begin
         vector_ack_out <= 1'b0;
         cnt <= 2'h0;
      end
      else if (vector_ack_out || !irq_req_in)
      begin
         vector_ack_out <= 1'b0; // one-cycle pulse, only while offered
         cnt <= 2'h0;
      end
      else if (cnt == delay_in)
         vector_ack_out <= 1'b1;
      else
         cnt <= cnt + 2'h1;
endmodule // pvic_exec_model

// File: pvic_ctrl_tb_top.sv
// pvic_ctrl_tb_top: self-checking bench for the interrupt controller
// assumes pvic_checker and pvic_exec_model are compiled before it
`timescale 1ns/10ps
module pvic_ctrl_tb_top
   import pvic_pkg::*;
;
   logic ref_clk_in, rst_in, per_clk_en_in, keypad_irq_input_in;
   logic ext_irq_pin_a_in, ext_irq_pin_b_in, return_from_interrupt_in;
   logic [1:0] ext_trigger_type_in, ext_flag_clear_in, tmr, ack_dly;
   logic [14:0] periph_req_in;
   logic [7:0] irq_enable_reg_a_in, irq_enable_reg_b_in;
   logic [7:0] prio_high_reg_a_in, prio_high_reg_b_in;
   logic [7:0] prio_low_reg_a_in, prio_low_reg_b_in;
   logic vector_ack_in, irq_req_out, wake_out;
   logic [15:0] irq_vector_out;
   logic [3:0] irq_slot_out, in_progress_out;
   logic [1:0] ext_request_flag_out, tmr_overflow_flag_out;
   logic [3:0] order [9] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha,
      4'hb, 4'hd};
   int n_errors = 0;
   int n_compared = 0;
   pvic_ctrl dut (.ref_clk_in, .rst_in, .per_clk_en_in, .ext_irq_pin_a_in,
      .ext_irq_pin_b_in, .keypad_irq_input_in, .ext_trigger_type_in,
      .ext_flag_clear_in, .tmr0_overflow_in(tmr[0]),
      .tmr1_overflow_in(tmr[1]), .periph_req_in, .irq_enable_reg_a_in,
      .irq_enable_reg_b_in, .prio_high_reg_a_in, .prio_high_reg_b_in,
      .prio_low_reg_a_in, .prio_low_reg_b_in, .vector_ack_in,
      .return_from_interrupt_in, .irq_req_out, .irq_vector_out,
      .irq_slot_out, .ext_request_flag_out, .tmr_overflow_flag_out,
      .in_progress_out, .wake_out);
   pvic_exec_model cpu (.ref_clk_in, .rst_in, .irq_req_in(irq_req_out),
      .delay_in(ack_dly), .vector_ack_out(vector_ack_in));
   // 25 MHz clock
   initial
   begin
      ref_clk_in = 1'b0;
      forever #20 ref_clk_in = ~ref_clk_in;
   end
   task complete_run;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp)
      begin
         $display("MISMATCH %s exp %h got %h", nm, exp, got);
         n_errors++;
      end
   endtask
   // wait for an offer, check it, then wait for the unit to take it
   task take(input logic [3:0] s);
      int i;
      logic [3:0] p;
      ack_dly = ~ack_dly; // alternate prompt and slow acks
      for (i = 0; i < 60 && irq_req_out !== 1'b1; i++)
         @(negedge ref_clk_in);
      cmp("offer", 16'h1, irq_req_out);
      if (irq_req_out !== 1'b1)
         complete_run();
      cmp("slot", s, irq_slot_out);
      cmp("vector", {s, 3'h0} + 16'h0003, irq_vector_out);
      p = in_progress_out;
      for (i = 0; i < 20 && in_progress_out === p; i++)
         @(negedge ref_clk_in);
      cmp("taken", 16'h0, irq_req_out);
      cmp("marked", 16'h1, 16'(in_progress_out !== p));
      if (in_progress_out === p)
         complete_run();
   endtask
   task quiet(input int n);
      repeat (n)
      begin
         @(negedge ref_clk_in);
         cmp("idle", 16'h0, irq_req_out);
      end
   endtask
   task ret;
      return_from_interrupt_in = 1'b1;
      @(negedge ref_clk_in);
      return_from_interrupt_in = 1'b0;
      @(negedge ref_clk_in);
   endtask
   // main sequence, inputs change on the falling edge
   initial
   begin
      {rst_in, per_clk_en_in, keypad_irq_input_in} = 3'h7;
      {ext_irq_pin_a_in, ext_irq_pin_b_in} = 2'h3;
      {ext_trigger_type_in, ext_flag_clear_in, tmr, ack_dly} = 8'h00;
      return_from_interrupt_in = 1'b0;
      periph_req_in = 15'h0000;
      irq_enable_reg_a_in = 8'hff;
      irq_enable_reg_b_in = 8'h5f;
      {prio_high_reg_a_in, prio_high_reg_b_in} = 16'h0000;
      {prio_low_reg_a_in, prio_low_reg_b_in} = 16'h0000;
      repeat (8) @(negedge ref_clk_in);
      rst_in = 1'b0;
      periph_req_in = 15'h2ff0;
      foreach (order[k])
      begin
         take(order[k]);
         periph_req_in[order[k]] = 1'b0;
         ret();
      end
      $display("test poll done");
      prio_high_reg_a_in = 8'h20;
      prio_low_reg_a_in = 8'h70;
      periph_req_in[4] = 1'b1;
      take(4'h4);
      periph_req_in[4] = 1'b0;
      cmp("inprog", 16'h2, in_progress_out);
      periph_req_in[6] = 1'b1;
      quiet(10);
      periph_req_in[5] = 1'b1;
      take(4'h5);
      periph_req_in[5] = 1'b0;
      cmp("inprog", 16'ha, in_progress_out);
      ret();
      cmp("inprog", 16'h2, in_progress_out);
      quiet(6);
      ret();
      take(4'h6);
      periph_req_in[6] = 1'b0;
      ret();
      $display("test nest done");
      irq_enable_reg_a_in = 8'h7f;
      periph_req_in[7] = 1'b1;
      quiet(8);
      irq_enable_reg_a_in = 8'hff;
      irq_enable_reg_b_in = 8'h5e;
      quiet(8);
      irq_enable_reg_b_in = 8'h5f;
      take(4'h7);
      periph_req_in[7] = 1'b0;
      ret();
      $display("test enable done");
      ext_trigger_type_in = 2'b01;
      ext_irq_pin_a_in = 1'b0;
      take(4'h0);
      cmp("edgeflag", 16'h0, ext_request_flag_out[0]);
      cmp("wake", 16'h1, wake_out);
      ext_irq_pin_a_in = 1'b1;
      ret();
      irq_enable_reg_a_in = 8'hfb; // slot 2 masked so the latch must hold
      ext_irq_pin_b_in = 1'b0;
      quiet(12);
      ext_irq_pin_b_in = 1'b1;
      quiet(12);
      cmp("lvlflag", 16'h1, ext_request_flag_out[1]);
      irq_enable_reg_a_in = 8'hff;
      take(4'h2);
      cmp("lvlflag", 16'h1, ext_request_flag_out[1]);
      ext_flag_clear_in = 2'b10;
      @(negedge ref_clk_in);
      ext_flag_clear_in = 2'b00;
      cmp("lvlflag", 16'h0, ext_request_flag_out[1]);
      ret();
      for (int t = 0; t < 2; t++)
      begin
         tmr[t] = 1'b1;
         @(negedge ref_clk_in);
         tmr[t] = 1'b0;
         cmp("tmrflag", 16'h1, tmr_overflow_flag_out[t]);
         take({2'b00, t[0], 1'b1});
         cmp("tmrflag", 16'h0, tmr_overflow_flag_out[t]);
         ret();
      end
      // keypad line is a level request on slot 11
      keypad_irq_input_in = 1'b0;
      take(4'hb);
      keypad_irq_input_in = 1'b1;
      quiet(12);
      ret();
      $display("test pins done");
      complete_run();
   end
endmodule // pvic_ctrl_tb_top
bind pvic_ctrl pvic_checker chk (.ref_clk_in, .rst_in, .ext_trigger_type_in,
   .tmr0_overflow_in, .irq_enable_reg_a_in, .irq_enable_reg_b_in,
   .prio_high_reg_a_in, .prio_high_reg_b_in, .prio_low_reg_a_in,
   .prio_low_reg_b_in, .vector_ack_in, .return_from_interrupt_in,
   .irq_req_out, .irq_vector_out, .irq_slot_out, .ext_request_flag_out,
   .tmr_overflow_flag_out, .in_progress_out);
